/* verilog/djp_top.sv */
// Dual joystick port: two sticks, each with two axis timers and two buttons.
// Assumes synchronous host I/O strobes and comparator inputs on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module djp_top
  import djp_pkg::*;
#(
  parameter int MIN_RISE = MIN_RISE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  // Host I/O cycles
  input wire logic [15:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  output logic [7:0] io_rdata,
  output logic io_claim,
  // Configuration access
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // Analog side of the timing pins
  input wire logic [NUM_AXES-1:0] rc_above,
  output logic [NUM_AXES-1:0] rc_pin_out,
  output logic [NUM_AXES-1:0] rc_pin_oe,
  // Buttons
  input wire logic [NUM_BUTTONS-1:0] button_in,
  // Game port enable, seen by power management
  output logic port_enabled
);

  // Address match against the programmed base
  function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] base);
    addr_hit = (addr == (base + PORT_OFFSET));
  endfunction

  // Configuration state
  logic [7:0] base_high;
  logic [7:0] base_low;
  logic activate;
  logic [15:0] base_addr;

  // Host port decode
  logic rd_hit;
  logic wr_hit;
  djp_wr_state_t wr_state;
  djp_wr_state_t next_wr_state;
  logic start_pulse;
  logic hold_pins;

  // Status sources
  logic [NUM_BUTTONS-1:0] button_q;
  logic [NUM_AXES-1:0] axis_bits;
  logic [NUM_AXES-1:0] axis_discharge;
  logic [7:0] status;

  // Configuration decode
  logic cfg_wr_high;
  logic cfg_wr_low;
  logic cfg_wr_act;
  logic cfg_wr_pwr;
  logic [7:0] next_cfg_rdata;
  logic [7:0] act_reg_view;
  logic [7:0] pwr_reg_view;

  // Base address assembly
  assign base_addr = {base_high, base_low};

  // Decode only while the unit is active
  assign rd_hit = activate && io_rd && addr_hit(io_addr, base_addr);
  assign wr_hit = activate && io_wr && addr_hit(io_addr, base_addr);

  // Configuration write decode
  assign cfg_wr_high = cfg_wr && (cfg_addr == CFG_BASE_HIGH);
  assign cfg_wr_low = cfg_wr && (cfg_addr == CFG_BASE_LOW);
  assign cfg_wr_act = cfg_wr && (cfg_addr == CFG_ACTIVATE);
  assign cfg_wr_pwr = cfg_wr && (cfg_addr == CFG_POWER_CTL);

  // Base address bytes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      base_high <= BASE_HIGH_RESET;
      base_low <= BASE_LOW_RESET;
    end else begin
      if (cfg_wr_high) begin
        base_high <= cfg_wdata;
      end
      if (cfg_wr_low) begin
        base_low <= cfg_wdata;
      end
    end
  end

  // One flop behind both the activate bit and power control bit 2
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      activate <= ACTIVATE_RESET;
    end else if (cfg_wr_pwr) begin
      activate <= cfg_wdata[POWER_GAME_BIT];
    end else if (cfg_wr_act) begin
      activate <= cfg_wdata[ACTIVATE_BIT];
    end
  end

  // Register views of the shared enable
  always_comb begin
    act_reg_view = 8'h00;
    act_reg_view[ACTIVATE_BIT] = activate;
    pwr_reg_view = 8'h00;
    pwr_reg_view[POWER_GAME_BIT] = activate;
  end

  // Configuration read mux
  always_comb begin
    next_cfg_rdata = 8'h00;
    if (cfg_rd) begin
      case (cfg_addr)
        CFG_BASE_HIGH: begin
          next_cfg_rdata = base_high;
        end
        CFG_BASE_LOW: begin
          next_cfg_rdata = base_low;
        end
        CFG_ACTIVATE: begin
          next_cfg_rdata = act_reg_view;
        end
        CFG_POWER_CTL: begin
          next_cfg_rdata = pwr_reg_view;
        end
        default: begin
          next_cfg_rdata = 8'h00;
        end
      endcase
    end
  end

  // Configuration read data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_rdata <= 8'h00;
    end else begin
      cfg_rdata <= next_cfg_rdata;
    end
  end

  // Enable flag out
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port_enabled <= ACTIVATE_RESET;
    end else begin
      port_enabled <= activate;
    end
  end

  // Write strobe tracking: restart fires when the strobe ends
  always_comb begin
    next_wr_state = wr_state;
    start_pulse = 1'b0;
    case (wr_state)
      DJP_WR_IDLE: begin
        if (wr_hit) begin
          next_wr_state = DJP_WR_ACTIVE;
        end
      end
      DJP_WR_ACTIVE: begin
        if (!wr_hit) begin
          next_wr_state = DJP_WR_IDLE;
          start_pulse = 1'b1;
        end
      end
      default: begin
        next_wr_state = DJP_WR_IDLE;
      end
    endcase
  end

  // Write state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_state <= DJP_WR_IDLE;
    end else begin
      wr_state <= next_wr_state;
    end
  end

  // Pins held low from the second cycle of the write strobe; released in the start cycle so the restart is not masked
  assign hold_pins = (wr_state == DJP_WR_ACTIVE) && wr_hit;

  // Four axis timers, one per axis status bit
  for (genvar i = 0; i < NUM_AXES; i++) begin : g_axis
    djp_axis_if ax ();

    assign ax.hold = hold_pins;
    assign ax.start = start_pulse;
    assign ax.above = rc_above[i];
    assign axis_bits[i] = ax.timing;
    assign axis_discharge[i] = ax.discharge;

    djp_axis_timer #(
      .MIN_RISE(MIN_RISE)
    ) u_timer (
      .clk_sys(clk_sys),
      .rst(rst),
      .ax(ax.timer)
    );
  end

  // Pin drive: low when discharging, released while timing
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rc_pin_out <= '0;
      rc_pin_oe <= '1;
    end else begin
      rc_pin_out <= '0;
      rc_pin_oe <= axis_discharge;
    end
  end

  // Button levels, refreshed every cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      button_q <= '0;
    end else begin
      button_q <= button_in;
    end
  end

  // Status layout
  always_comb begin
    status = STATUS_RESET;
    status[STAT_AXIS_LSB +: NUM_AXES] = axis_bits;
    status[STAT_BTN_LSB +: NUM_BUTTONS] = button_q;
  end

  // Host read data and claim flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      io_rdata <= STATUS_RESET;
      io_claim <= 1'b0;
    end else begin
      io_rdata <= rd_hit ? status : 8'h00;
      io_claim <= rd_hit || wr_hit;
    end
  end

endmodule
`default_nettype wire

/* pkg/djp_pkg.sv */
// Constants and types for the dual joystick port block.
// Assumes a single 250 MHz system clock and a synchronous reset.
package djp_pkg;

  // Clock rate
  localparam int CLK_MHZ = 250;

  // Port register offset from the programmed base address
  localparam logic [15:0] PORT_OFFSET = 16'h0000;

  // Port status register layout
  localparam int STAT_AXIS_LSB = 0;
  localparam int STAT_BTN_LSB = 4;
  localparam int NUM_AXES = 4;
  localparam int NUM_BUTTONS = 4;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // Configuration register indices
  localparam logic [7:0] CFG_BASE_HIGH = 8'h60;
  localparam logic [7:0] CFG_BASE_LOW = 8'h61;
  localparam logic [7:0] CFG_ACTIVATE = 8'h30;
  localparam logic [7:0] CFG_POWER_CTL = 8'h22;

  // Bit positions of the mirrored enable
  localparam int ACTIVATE_BIT = 0;
  localparam int POWER_GAME_BIT = 2;

  // Configuration reset values
  localparam logic [7:0] BASE_HIGH_RESET = 8'h00;
  localparam logic [7:0] BASE_LOW_RESET = 8'h00;
  localparam logic ACTIVATE_RESET = 1'b0;

  // Fastest legal rise on a timing pin, and its cycle count (rounded up)
  localparam int MIN_RISE_NS = 20000;
  localparam int MIN_RISE_CYC = (MIN_RISE_NS * CLK_MHZ + 999) / 1000;
  localparam int RISE_CNT_W = 16;

  // Tracking of the host write strobe
  typedef enum logic [0:0] {
    DJP_WR_IDLE,
    DJP_WR_ACTIVE
  } djp_wr_state_t;

endpackage

/* pkg/djp_axis_if.sv */
// Carrier between the port logic and one axis one-shot timer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface djp_axis_if;
  logic hold;      // Write strobe past its first cycle: keep pin discharged
  logic start;     // One-cycle pulse at the write strobe's trailing edge
  logic above;     // Timing pin has crossed two thirds of reference
  logic timing;    // Axis output bit
  logic discharge; // Pull the timing pin to zero

  modport port (output hold, output start, output above, input timing, input discharge);
  modport timer (input hold, input start, input above, output timing, output discharge);
endinterface
`default_nettype wire

/* verilog/djp_axis_timer.sv */
// One-shot timer for a single joystick axis.
// Assumes the comparator input is synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module djp_axis_timer
  import djp_pkg::*;
#(
  parameter int MIN_RISE = MIN_RISE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  djp_axis_if.timer ax
);

  logic [RISE_CNT_W-1:0] blank_cnt;
  logic blanking;
  logic trip;

  // Comparator ignored until the fastest legal rise has elapsed
  assign blanking = (blank_cnt != '0);
  assign trip = ax.timing && !blanking && ax.above;

  // Output bit and discharge switch of the one-shot
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ax.timing <= 1'b0;
      ax.discharge <= 1'b1;
      blank_cnt <= '0;
    end else if (ax.hold) begin
      ax.timing <= 1'b0;
      ax.discharge <= 1'b1;
      blank_cnt <= '0;
    end else if (ax.start) begin
      ax.timing <= 1'b1;
      ax.discharge <= 1'b0;
      blank_cnt <= RISE_CNT_W'(MIN_RISE);
    end else if (trip) begin
      ax.timing <= 1'b0;
      ax.discharge <= 1'b1;
    end else if (blanking) begin
      blank_cnt <= blank_cnt - 1'b1;
    end
  end

endmodule
`default_nettype wire

/* dv/djp_top_properties.sv */
// Port checker for the dual joystick port.
// Sees only djp_top pins; bound to every instance.
`timescale 1ns/1ps
`default_nettype none
module djp_top_chk
  import djp_pkg::*;
#(
  parameter int MIN_RISE = MIN_RISE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_rdata,
  input wire logic io_claim,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic [NUM_AXES-1:0] rc_pin_out,
  input wire logic [NUM_AXES-1:0] rc_pin_oe,
  input wire logic [NUM_BUTTONS-1:0] button_in,
  input wire logic port_enabled
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Claims, data and pins
  chk_claim_cause: assert property (!(io_rd || io_wr) |=> !io_claim)
    else $error("claim without strobe");
  chk_rdata_idle: assert property (!io_rd |=> io_rdata == 8'h00)
    else $error("read data without read");
  chk_claim_gated: assert property (io_claim |-> port_enabled || $past(port_enabled))
    else $error("claim while port off");
  chk_button_level: assert property (io_claim && $past(io_rd) |-> io_rdata[7:4] == $past(button_in, 2))
    else $error("button bits wrong");
  chk_write_discharge: assert property ((io_wr && io_claim)[*3] |-> rc_pin_oe == 4'hf)
    else $error("pins not held low in write");
  chk_pin_low: assert property (rc_pin_out == 4'h0)
    else $error("pin driven high");
  chk_reset_state: assert property ($fell(rst) |-> !io_claim && rc_pin_oe == 4'hf && !port_enabled)
    else $error("bad reset state");
  chk_cfg_idle: assert property (!cfg_rd |=> cfg_rdata == 8'h00)
    else $error("config data without read");
  chk_power_mirror: assert property (cfg_wr && cfg_addr == CFG_POWER_CTL |=> ##1
    port_enabled == $past(cfg_wdata[POWER_GAME_BIT], 2)) else $error("power bit not mirrored");
  chk_activate_copy: assert property (cfg_wr && cfg_addr == CFG_ACTIVATE |=> ##1
    port_enabled == $past(cfg_wdata[ACTIVATE_BIT], 2)) else $error("activate not copied");
  // Main scenarios
  cover property (io_claim && $past(io_rd));
  cover property ((io_wr && io_claim)[*3]);
  cover property ($fell(rc_pin_oe[3]));
endmodule
bind djp_top djp_top_chk #(.MIN_RISE(MIN_RISE)) djp_top_chk_inst (.clk_sys, .rst, .io_rd, .io_wr,
  .io_rdata, .io_claim, .cfg_addr, .cfg_rd, .cfg_wr, .cfg_wdata, .cfg_rdata, .rc_pin_out,
  .rc_pin_oe, .button_in, .port_enabled);
`default_nettype wire

/* dv/djp_pot_model.sv */
// Potentiometer and RC network on the four timing pins.
// Pin charges while released; comparator high past its rise time.
`timescale 1ns/1ps
`default_nettype none
module djp_pot_model
  import djp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [NUM_AXES-1:0] rc_pin_oe,
  input wire logic [63:0] rise,
  output logic [NUM_AXES-1:0] rc_above
);
  logic [15:0] cnt [NUM_AXES];
  // Charge time since release; a pin held low reads below threshold
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NUM_AXES; i++) begin
      cnt[i] <= rc_pin_oe[i] ? 16'h0 : cnt[i] + 16'h1;
      rc_above[i] <= !rc_pin_oe[i] && cnt[i] >= rise[16*i +: 16];
    end
  end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for djp_top.
// Assumes the checker binds itself and the pot model drives the comparators.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import djp_pkg::*;
  ;
  logic clk_sys = 1'b0, rst = 1'b1, io_rd = 1'b0, io_wr = 1'b0, cfg_rd = 1'b0, cfg_wr = 1'b0;
  logic [15:0] io_addr = 16'h0, base = 16'h0, lfsr = 16'hcc25;
  logic [7:0] cfg_addr = 8'h0, cfg_wdata = 8'h0, io_rdata, cfg_rdata;
  logic [3:0] button_in = 4'h0, rc_above, rc_pin_out, rc_pin_oe;
  logic io_claim, port_enabled, r_io = 1'b0, r_cfg = 1'b0;
  logic [63:0] rise = {16'h46, 16'h32, 16'h1e, 16'h0a};
  logic [8:0] exp_q [$];
  int err_count = 0, n_checks = 0;
  always #2 clk_sys = ~clk_sys;
  djp_top #(.MIN_RISE(4)) djp_top_inst (.clk_sys, .rst, .io_addr, .io_rd, .io_wr, .io_rdata,
    .io_claim, .cfg_addr, .cfg_rd, .cfg_wr, .cfg_wdata, .cfg_rdata, .rc_above, .rc_pin_out,
    .rc_pin_oe, .button_in, .port_enabled);
  djp_pot_model djp_pot_model_inst (.clk_sys, .rc_pin_oe, .rise, .rc_above);
  function automatic logic [15:0] lfsr_next(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk_io(logic [8:0] e);
    n_checks++;
    if ({io_claim, io_rdata} !== e) begin
      err_count++;
      $display("unexpected at %0t: port read got %h want %h", $time, {io_claim, io_rdata}, e);
    end
  endtask
  task automatic chk_cfg(logic [8:0] e);
    n_checks++;
    if ({1'b1, cfg_rdata} !== e) begin
      err_count++;
      $display("unexpected at %0t: config read got %h want %h", $time, cfg_rdata, e[7:0]);
    end
  endtask
  task automatic cfg_w(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
  endtask
  task automatic cfg_r(logic [7:0] a, logic [7:0] e);
    @(posedge clk_sys);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    exp_q.push_back({1'b1, e});
    @(posedge clk_sys);
    cfg_rd <= 1'b0;
  endtask
  task automatic io_r(logic [15:0] a, logic [8:0] e);
    @(posedge clk_sys);
    io_addr <= a;
    io_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    io_rd <= 1'b0;
  endtask
  task automatic io_w(logic [15:0] a, int n);
    @(posedge clk_sys);
    io_addr <= a;
    io_wr <= 1'b1;
    repeat (n) @(posedge clk_sys);
    io_wr <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d, errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Read results land two edges after the strobe
  always @(posedge clk_sys) begin
    if (r_io) chk_io(exp_q.pop_front());
    if (r_cfg) chk_cfg(exp_q.pop_front());
    r_io <= io_rd;
    r_cfg <= cfg_rd;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    io_r(16'h0, 9'h000);
    cfg_r(CFG_ACTIVATE, 8'h00);
    lfsr = lfsr_next(lfsr);
    base = lfsr;
    cfg_w(CFG_BASE_HIGH, base[15:8]);
    cfg_w(CFG_BASE_LOW, base[7:0]);
    cfg_r(CFG_BASE_HIGH, base[15:8]);
    cfg_r(CFG_BASE_LOW, base[7:0]);
    cfg_r(8'h31, 8'h00);
    cfg_w(CFG_POWER_CTL, 8'h04);
    cfg_r(CFG_ACTIVATE, 8'h01);
    io_r(base, 9'h100);
    io_r(base + 16'h1, 9'h000);
    // Long writes restart timers; axes time out in rise order
    for (int t = 2; t <= 82; t += 20) begin
      lfsr = lfsr_next(lfsr);
      button_in <= lfsr[3:0];
      io_w(base, 30);
      repeat (t) @(posedge clk_sys);
      io_r(base, {1'b1, button_in, t < 73, t < 53, t < 33, t < 13});
    end
    cfg_w(CFG_ACTIVATE, 8'h00);
    cfg_r(CFG_POWER_CTL, 8'h00);
    io_w(base, 30);
    io_r(base, 9'h000);
    cfg_w(CFG_ACTIVATE, 8'h01);
    io_r(base, {1'b1, button_in, 4'h0});
    repeat (4) @(posedge clk_sys);
    if (exp_q.size() != 0) err_count++;
    finish_test();
  end
endmodule
`default_nettype wire
